// ===== ifeb_pkg.sv
package ifeb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_PINS = 6;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_SRC = 15;
  localparam int ID_W = 4;

  // register offsets
  localparam logic [3:0] OFS_PIN_FUNC = 4'h0;
  localparam logic [3:0] OFS_EDGE_SEL = 4'h1;
  localparam logic [3:0] OFS_EXT_EN = 4'h2;
  localparam logic [3:0] OFS_TT_EN = 4'h3;
  localparam logic [3:0] OFS_EN3 = 4'h4;
  localparam logic [3:0] OFS_EXT_FLAGS = 4'h5;
  localparam logic [3:0] OFS_TT_FLAGS = 4'h6;
  localparam logic [3:0] OFS_CS_FLAGS = 4'h7;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h8;
  localparam logic [3:0] OFS_EVT_MASK = 4'h9;

  // bits forced to 1 / to 0 on read, never stored
  localparam logic [7:0] EDGE_ONES = 8'hec;
  localparam logic [7:0] EXT_EN_ONES = 8'hc0;
  localparam logic [7:0] EN3_ONES = 8'h3c;
  localparam logic [7:0] EXT_FLAGS_ONES = 8'hc0;
  localparam logic [7:0] TT_FLAGS_ZEROS = 8'hc0;
  localparam logic [7:0] CS_FLAGS_ONES = 8'h3c;
  localparam logic [7:0] CS_FLAGS_ZEROS = 8'h40;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int NOISE_EN_BIT = 7;
  localparam int DT_BIT = 5;
  localparam int AD_BIT = 7;
  localparam int SPARE_BIT = 6;
  localparam int S2_BIT = 1;
  localparam int S1_BIT = 0;

  // event status bits
  localparam int EV_EXT = 0;
  localparam int EV_TIMER = 1;
  localparam int EV_DT = 2;
  localparam int EV_AD = 3;
  localparam int EV_SERIAL = 4;
  localparam int EV_NOISE = 5;

  // noise canceller sampling period in states (cycles)
  localparam int NOISE_STATES = 256;
  localparam logic [7:0] NOISE_LAST = 8'(NOISE_STATES - 1);

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] pin_lvl;
    logic [7:0] noise_cnt;
    logic noise_smp;
    logic noise_lvl;
    logic [7:0] pin_func;
    logic [7:0] edge_sel;
    logic [7:0] ext_en;
    logic [7:0] tt_en;
    logic [7:0] en3;
    logic [7:0] ext_flags;
    logic [7:0] tt_flags;
    logic [7:0] cs_flags;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [7:0] rd_data;
    logic irq;
    logic pend_valid;
    logic [3:0] pend_id;
  } ifeb_state_t;
endpackage

// ===== ifeb_top.sv
`timescale 1ns/1ps
module ifeb_top
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [ifeb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ifeb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ifeb_pkg::DATA_W-1:0] rdata_o,
  // external request pins, asynchronous
  input wire logic [ifeb_pkg::NUM_PINS-1:0] irq_pin_i,
  // peripheral request pulses, same clock
  input wire logic [ifeb_pkg::NUM_TIMERS-1:0] timer_ovf_i,
  input wire logic conv_done_i,
  input wire logic serial_one_evt_i,
  input wire logic serial_two_evt_i,
  // system mode for direct transfer
  input wire logic subactive_i,
  input wire logic sleep_exec_i,
  input wire logic direct_transfer_on_i,
  input wire logic low_speed_select_i,
  // toward the cpu core
  output logic req_valid_o,
  output logic [ifeb_pkg::ID_W-1:0] req_id_o,
  output logic irq_o
);
  import ifeb_pkg::*;

  ifeb_state_t st_r;
  ifeb_state_t st_nxt;
  logic [1:0] rst_pipe_r;
  logic rst_sync_n;

  // reset enters asynchronously, is released on the clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_pipe_r <= 2'b00;
    end
    else
    begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_r[1];

  // write-zero clears; a set in the same cycle wins
  function automatic logic [7:0] clr_set(input logic [7:0] flags, input logic hit, input logic [7:0] wd,
                                         input logic [7:0] set);
    logic [7:0] clr;
    clr = hit ? ~wd : 8'h00;
    clr_set = (flags & ~clr) | set;
  endfunction

  // fixed read values for reserved bits
  function automatic logic [7:0] rd_fix(input logic [7:0] val, input logic [7:0] ones, input logic [7:0] zeros);
    rd_fix = (val | ones) & ~zeros;
  endfunction

  function automatic logic edge_hit(input logic old_lvl, input logic new_lvl, input logic rising);
    edge_hit = rising ? (new_lvl & ~old_lvl) : (old_lvl & ~new_lvl);
  endfunction

  logic [NUM_SRC-1:0] active;
  logic [NUM_PINS-1:0] pin_new;
  logic [NUM_PINS-1:0] ext_set;
  logic [NUM_PINS-1:0] pin_rise;
  logic [7:0] tt_set;
  logic [7:0] cs_set;
  logic wr_hit_ext;
  logic wr_hit_tt;
  logic wr_hit_cs;
  logic noise_on;
  logic noise_tick;
  logic noise_reject;
  logic lvl0_old;
  logic lvl0_new;
  logic dt_set;
  logic [7:0] rd_mux;
  logic [7:0] evt_set;
  logic [7:0] evt_clr;

  always_comb
  begin
    st_nxt = st_r;

    // pin synchronisers: level moves once stage two and three agree
    st_nxt.sync1 = irq_pin_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_new[i] = (st_r.sync2[i] == st_r.sync3[i]) ? st_r.sync3[i] : st_r.pin_lvl[i];
    end
    st_nxt.pin_lvl = pin_new;

    // pin 0 noise canceller; a level counts only once two successive samples, 256 cycles apart, agree
    noise_on = st_r.pin_func[NOISE_EN_BIT];
    noise_tick = noise_on && (st_r.noise_cnt == NOISE_LAST);
    noise_reject = 1'b0;
    st_nxt.noise_cnt = noise_on ? st_r.noise_cnt + 8'h01 : 8'h00;
    if (noise_tick)
    begin
      st_nxt.noise_smp = st_r.pin_lvl[0];
      if (st_r.pin_lvl[0] == st_r.noise_smp)
      begin
        st_nxt.noise_lvl = st_r.pin_lvl[0];
      end
      else
      begin
        noise_reject = 1'b1;
      end
    end
    else if (!noise_on)
    begin
      // track the pin so enabling the filter makes no false edge
      st_nxt.noise_smp = pin_new[0];
      st_nxt.noise_lvl = pin_new[0];
    end
    lvl0_old = noise_on ? st_r.noise_lvl : st_r.pin_lvl[0];
    lvl0_new = noise_on ? st_nxt.noise_lvl : pin_new[0];

    // edge select: pins 4, 1, 0 selectable, others falling only
    pin_rise = '0;
    pin_rise[4] = st_r.edge_sel[4];
    pin_rise[1] = st_r.edge_sel[1];
    pin_rise[0] = st_r.edge_sel[0];
    ext_set[0] = st_r.pin_func[0] && edge_hit(lvl0_old, lvl0_new, pin_rise[0]);
    for (int i = 1; i < NUM_PINS; i++)
    begin
      ext_set[i] = st_r.pin_func[i] && edge_hit(st_r.pin_lvl[i], pin_new[i], pin_rise[i]);
    end

    // peripheral set sources
    dt_set = subactive_i && sleep_exec_i && direct_transfer_on_i && !low_speed_select_i
             && st_r.tt_en[DT_BIT];
    tt_set = {2'b00, dt_set, timer_ovf_i};
    cs_set = '0;
    cs_set[AD_BIT] = conv_done_i;
    cs_set[S2_BIT] = serial_two_evt_i;
    cs_set[S1_BIT] = serial_one_evt_i;

    // register writes
    wr_hit_ext = wr_i && (addr_i == OFS_EXT_FLAGS);
    wr_hit_tt = wr_i && (addr_i == OFS_TT_FLAGS);
    wr_hit_cs = wr_i && (addr_i == OFS_CS_FLAGS);
    if (wr_i)
    begin
      case (addr_i)
        OFS_PIN_FUNC: st_nxt.pin_func = wdata_i;
        OFS_EDGE_SEL: st_nxt.edge_sel = wdata_i & ~EDGE_ONES;
        OFS_EXT_EN: st_nxt.ext_en = wdata_i & ~EXT_EN_ONES;
        OFS_TT_EN: st_nxt.tt_en = wdata_i;
        OFS_EN3: st_nxt.en3 = wdata_i & ~EN3_ONES;
        OFS_EVT_MASK: st_nxt.evt_mask = wdata_i;
        default: st_nxt.pin_func = st_r.pin_func;
      endcase
    end

    // flags survive acceptance; only a zero write removes them
    st_nxt.ext_flags = clr_set(st_r.ext_flags, wr_hit_ext, wdata_i, {2'b00, ext_set}) & ~EXT_FLAGS_ONES;
    st_nxt.tt_flags = clr_set(st_r.tt_flags, wr_hit_tt, wdata_i, tt_set) & ~TT_FLAGS_ZEROS;
    st_nxt.cs_flags = clr_set(st_r.cs_flags, wr_hit_cs, wdata_i, cs_set)
                      & ~(CS_FLAGS_ONES | CS_FLAGS_ZEROS);

    // read mux; reserved bits come from constants, not storage
    case (addr_i)
      OFS_PIN_FUNC: rd_mux = st_r.pin_func;
      OFS_EDGE_SEL: rd_mux = rd_fix(st_r.edge_sel, EDGE_ONES, RST_ZERO);
      OFS_EXT_EN: rd_mux = rd_fix(st_r.ext_en, EXT_EN_ONES, RST_ZERO);
      OFS_TT_EN: rd_mux = st_r.tt_en;
      OFS_EN3: rd_mux = rd_fix(st_r.en3, EN3_ONES, RST_ZERO);
      OFS_EXT_FLAGS: rd_mux = rd_fix(st_r.ext_flags, EXT_FLAGS_ONES, RST_ZERO);
      OFS_TT_FLAGS: rd_mux = rd_fix(st_r.tt_flags, RST_ZERO, TT_FLAGS_ZEROS);
      OFS_CS_FLAGS: rd_mux = rd_fix(st_r.cs_flags, CS_FLAGS_ONES, CS_FLAGS_ZEROS);
      OFS_EVT_STATUS: rd_mux = st_r.evt_status;
      OFS_EVT_MASK: rd_mux = st_r.evt_mask;
      default: rd_mux = 8'h00;
    endcase
    st_nxt.rd_data = rd_i ? rd_mux : 8'h00;

    // sticky event status, cleared by reading it; new events win
    evt_set = '0;
    evt_set[EV_EXT] = |ext_set;
    evt_set[EV_TIMER] = |timer_ovf_i;
    evt_set[EV_DT] = dt_set;
    evt_set[EV_AD] = conv_done_i;
    evt_set[EV_SERIAL] = serial_one_evt_i | serial_two_evt_i;
    evt_set[EV_NOISE] = noise_reject;
    evt_clr = (rd_i && (addr_i == OFS_EVT_STATUS)) ? 8'hff : 8'h00;
    st_nxt.evt_status = (st_r.evt_status & ~evt_clr) | evt_set;
    st_nxt.irq = |(st_r.evt_status & st_r.evt_mask);

    // gate each flag with its enable
    active[5:0] = st_r.ext_flags[5:0] & st_r.ext_en[5:0];
    active[6] = st_r.tt_flags[DT_BIT] & st_r.tt_en[DT_BIT];
    active[11:7] = st_r.tt_flags[4:0] & st_r.tt_en[4:0];
    active[12] = st_r.cs_flags[AD_BIT] & st_r.en3[AD_BIT];
    active[13] = st_r.cs_flags[S1_BIT] & st_r.en3[S1_BIT];
    active[14] = st_r.cs_flags[S2_BIT] & st_r.en3[S2_BIT];

    // lowest index is highest priority; others stay pending in their flags
    st_nxt.pend_valid = |active;
    st_nxt.pend_id = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (active[i])
      begin
        st_nxt.pend_id = 4'(i);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rd_data;
  assign irq_o = st_r.irq;
  assign req_valid_o = st_r.pend_valid;
  assign req_id_o = st_r.pend_id;
endmodule

// ===== ifeb_asserts.sv
`timescale 1ns/1ps
module ifeb_asserts
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [ifeb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ifeb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ifeb_pkg::DATA_W-1:0] rdata_o,
  // request sources
  input wire logic [ifeb_pkg::NUM_TIMERS-1:0] timer_ovf_i,
  input wire logic conv_done_i,
  input wire logic serial_one_evt_i,
  input wire logic serial_two_evt_i,
  // toward the cpu
  input wire logic req_valid_o,
  input wire logic [ifeb_pkg::ID_W-1:0] req_id_o
);
  import ifeb_pkg::*;
  // shadows of the enables; writes in the two cycles after reset release are not expected
  logic [7:0] en3_sh;
  logic [4:0] tt_sh;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en3_sh <= 8'h00;
      tt_sh <= 5'h00;
    end
    else if (wr_i && ce_i)
    begin
      if (addr_i == OFS_EN3)
        en3_sh <= wdata_i & 8'hc3;
      if (addr_i == OFS_TT_EN)
        tt_sh <= wdata_i[4:0];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_en3_rd; rd_i && addr_i == OFS_EN3 |=> rdata_o == (en3_sh | EN3_ONES); endproperty
  a_en3_rd: assert property (p_en3_rd) else $error("enable three read back wrong");
  property p_cs_rd; rd_i && addr_i == OFS_CS_FLAGS |=> rdata_o[5:2] == 4'hf && !rdata_o[6]; endproperty
  a_cs_rd: assert property (p_cs_rd) else $error("converter serial fixed bits wrong");
  property p_ext_rd; rd_i && addr_i == OFS_EXT_FLAGS |=> rdata_o[7:6] == 2'b11; endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("external flag fixed bits wrong");
  property p_tt_rd; rd_i && addr_i == OFS_TT_FLAGS |=> rdata_o[7:6] == 2'b00; endproperty
  a_tt_rd: assert property (p_tt_rd) else $error("timer flag fixed bits wrong");
  property p_tmr_req; ce_i && (timer_ovf_i & tt_sh) != 5'h00 && !wr_i |-> ##2 req_valid_o; endproperty
  a_tmr_req: assert property (p_tmr_req) else $error("enabled timer gave no request");
  property p_cs_req; ce_i && ((conv_done_i && en3_sh[7]) || (serial_one_evt_i && en3_sh[0])
    || (serial_two_evt_i && en3_sh[1])) && !wr_i |-> ##2 req_valid_o; endproperty
  a_cs_req: assert property (p_cs_req) else $error("enabled peripheral gave no request");
  property p_hold; $fell(req_valid_o) |-> $past(wr_i, 2); endproperty
  a_hold: assert property (p_hold) else $error("request dropped without a write");
  property p_id; req_valid_o |-> req_id_o <= 4'he; endproperty
  a_id: assert property (p_id) else $error("request id out of range");
endmodule
bind ifeb_top ifeb_asserts u_chk (.*);

// ===== ifeb_src_model.sv
`timescale 1ns/1ps
module ifeb_src_model
(
  // clock
  input wire logic clk_sys_i,
  // peripheral and pin requests
  output logic [4:0] timer_ovf_o,
  output logic conv_done_o,
  output logic serial_one_o,
  output logic serial_two_o,
  output logic [5:0] irq_pin_o,
  // power mode
  output logic subactive_o,
  output logic sleep_exec_o,
  output logic dt_on_o,
  output logic low_speed_o
);
  initial
  begin
    {serial_two_o, serial_one_o, conv_done_o, timer_ovf_o} = 8'h00;
    irq_pin_o = 6'h3f;
    {subactive_o, dt_on_o, low_speed_o, sleep_exec_o} = 4'h0;
  end
  task automatic fire(input logic [7:0] m);
    @(posedge clk_sys_i);
    {serial_two_o, serial_one_o, conv_done_o, timer_ovf_o} <= m;
    @(posedge clk_sys_i);
    {serial_two_o, serial_one_o, conv_done_o, timer_ovf_o} <= 8'h00;
  endtask
  // held well past the pin synchroniser
  task automatic pins(input logic [5:0] v);
    @(posedge clk_sys_i);
    irq_pin_o <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
  // mode settles a cycle before the sleep pulse
  task automatic go_sleep(input logic [2:0] m);
    @(posedge clk_sys_i);
    {subactive_o, dt_on_o, low_speed_o} <= m;
    @(posedge clk_sys_i);
    sleep_exec_o <= 1'b1;
    @(posedge clk_sys_i);
    sleep_exec_o <= 1'b0;
  endtask
endmodule

// ===== interrupt_flag_enable_bank_tb.sv
`timescale 1ns/1ps
module interrupt_flag_enable_bank_tb;
  import ifeb_pkg::*;
  logic clk_sys_i, rst_n_i, wr_i, rd_i, req_valid_o, irq_o;
  logic ce_i;
  logic [3:0] addr_i, req_id_o;
  logic [7:0] wdata_i, rdata_o;
  logic [4:0] timer_ovf_i;
  logic [5:0] irq_pin_i;
  logic conv_done_i, serial_one_evt_i, serial_two_evt_i;
  logic subactive_i, sleep_exec_i, direct_transfer_on_i, low_speed_select_i;
  int n_fail = 0;
  int samples_checked = 0;
  logic [7:0] rv [7] = '{8'hec, 8'hc0, 8'h00, 8'h3c, 8'hc0, 8'h00, 8'h3c};
  ifeb_top DUT (.clk_sys_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_pin_i, .timer_ovf_i, .conv_done_i, .serial_one_evt_i, .serial_two_evt_i, .subactive_i,
    .sleep_exec_i, .direct_transfer_on_i, .low_speed_select_i, .req_valid_o, .req_id_o, .irq_o);
  ifeb_src_model u_src (.clk_sys_i, .timer_ovf_o(timer_ovf_i), .conv_done_o(conv_done_i),
    .serial_one_o(serial_one_evt_i), .serial_two_o(serial_two_evt_i), .irq_pin_o(irq_pin_i),
    .subactive_o(subactive_i), .sleep_exec_o(sleep_exec_i), .dt_on_o(direct_transfer_on_i),
    .low_speed_o(low_speed_select_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    test_done;
  end
  initial
  begin
    {addr_i, wdata_i, wr_i, rd_i} = '0;
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 7; i++)
      rdc(4'(i + 1), rv[i]);
    rdc(4'hf, 8'h00);
    wr(OFS_EN3, 8'h40);
    rdc(OFS_EN3, 8'h7c);
    wr(OFS_EN3, 8'hff);
    rdc(OFS_EN3, 8'hff);
    $display("test 1 done");
    wr(OFS_TT_EN, 8'h1f);
    u_src.fire(8'h1f);
    wt(2);
    chk(req_id_o, 8'h07);
    wt(20);
    rdc(OFS_TT_FLAGS, 8'h1f);
    wr(OFS_TT_FLAGS, 8'h3e);
    rdc(OFS_TT_FLAGS, 8'h1e);
    chk(req_id_o, 8'h08);
    wr(OFS_TT_FLAGS, 8'h00);
    wt(1);
    chk(req_valid_o, 8'h00);
    wr(OFS_TT_EN, 8'h00);
    u_src.fire(8'h04);
    wt(2);
    chk(req_valid_o, 8'h00);
    rdc(OFS_TT_FLAGS, 8'h04);
    // set and clear land on the same edge
    fork
      u_src.fire(8'h01);
      wr(OFS_TT_FLAGS, 8'h00);
    join
    rdc(OFS_TT_FLAGS, 8'h01);
    wr(OFS_TT_FLAGS, 8'h00);
    // a pulse while frozen is lost
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    u_src.fire(8'h08);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rdc(OFS_TT_FLAGS, 8'h00);
    $display("test 2 done");
    u_src.fire(8'he0);
    rdc(OFS_CS_FLAGS, 8'hbf);
    wr(OFS_EN3, 8'h80);
    wt(1);
    chk(req_id_o, 8'h0c);
    wr(OFS_EN3, 8'h03);
    wt(1);
    chk(req_id_o, 8'h0d);
    wr(OFS_CS_FLAGS, 8'h3e);
    wt(1);
    chk(req_id_o, 8'h0e);
    wr(OFS_CS_FLAGS, 8'h00);
    rdc(OFS_CS_FLAGS, 8'h3c);
    $display("test 3 done");
    wr(OFS_PIN_FUNC, 8'h3f);
    u_src.pins(6'h00);
    rdc(OFS_EXT_FLAGS, 8'hff);
    wr(OFS_EXT_FLAGS, 8'hc0);
    wr(OFS_EDGE_SEL, 8'h13);
    u_src.pins(6'h3f);
    rdc(OFS_EXT_FLAGS, 8'hd3);
    wr(OFS_EXT_EN, 8'h02);
    wt(1);
    chk(req_id_o, 8'h01);
    wr(OFS_EXT_EN, 8'h00);
    wr(OFS_EXT_FLAGS, 8'h00);
    wr(OFS_TT_EN, 8'h20);
    u_src.go_sleep(3'b110);
    rdc(OFS_TT_FLAGS, 8'h20);
    wr(OFS_TT_FLAGS, 8'h00);
    u_src.go_sleep(3'b111);
    rdc(OFS_TT_FLAGS, 8'h00);
    $display("test 4 done");
    wr(OFS_EVT_MASK, 8'h02);
    wt(1);
    chk(irq_o, 8'h01);
    rdc(OFS_EVT_STATUS, 8'h1f);
    wt(1);
    chk(irq_o, 8'h00);
    u_src.fire(8'h02);
    wt(2);
    chk(irq_o, 8'h01);
    rdc(OFS_EVT_STATUS, 8'h02);
    $display("test 5 done");
    wr(OFS_PIN_FUNC, 8'h81);
    u_src.pins(6'h3e);
    u_src.pins(6'h3f);
    rdc(OFS_EXT_FLAGS, 8'hc0);
    u_src.pins(6'h3e);
    wt(600);
    u_src.pins(6'h3f);
    wt(600);
    rdc(OFS_EXT_FLAGS, 8'hc1);
    rdc(OFS_EVT_STATUS, 8'h21);
    $display("test 6 done");
    test_done;
  end
endmodule
